// [hw/ffs_consts.svh]
// constant macros for the fan fail-safe and tach blanking block
`ifndef FFS_CONSTS_SVH
`define FFS_CONSTS_SVH
// command and response type codes
`define FFS_CMD_FAILSAFE 8'h19
`define FFS_CMD_GLITCH 8'h1A
`define FFS_CMD_QUERY 8'h1B
`define FFS_RSP_FLAG 8'h40
`define FFS_LEN_FAILSAFE 8'h02
`define FFS_LEN_GLITCH 8'h04
`define FFS_LEN_QUERY 8'h00
`define FFS_LEN_QRSP 8'h05
`define FFS_MASK_MAX 8'h0F
// interrupt register port places
`define FFS_ADDR_STATUS 2'd0
`define FFS_ADDR_MASK 2'd1
`define FFS_ADDR_SAFE 2'd2
// fan count and the implemented fans
`define FFS_NFAN 4
`define FFS_NLIVE 3
// timing: 25 MHz clock, 1/8 s tick, 552.5 us blanking count, 100 counts per pwm period
`define FFS_CLK_HZ 25000000
`define FFS_TICK_NS 125000000
`define FFS_CNT_NS 552500
`define FFS_CLK_NS 40
`define FFS_TICK_CYC (`FFS_TICK_NS / `FFS_CLK_NS)
`define FFS_CNT_CYC (`FFS_CNT_NS / `FFS_CLK_NS)
`define FFS_PWM_STEPS 8'd100
`define FFS_PWM_FULL 8'h64
// reset values
`define FFS_GLITCH_RST 8'h01
`define FFS_TIMEOUT_RST 8'h01
`define FFS_POWER_RST 8'h64
`define FFS_QRSP_BYTES 3'd5
`endif

// [hw/ffs_pkg.sv]
// types for the fan fail-safe and tach blanking block
package ffs_pkg;
  // command parser states, one-hot
  typedef enum logic [3:0] {
    FFS_IDLE = 4'b0001,
    FFS_LEN = 4'b0010,
    FFS_DATA = 4'b0100,
    FFS_RESP = 4'b1000
  } ffs_state_t;
endpackage : ffs_pkg

// [hw/ffs_fan_failsafe.sv]
// fan fail-safe supervisor, pwm and tach blanking with command packet port
//
// Summary of operation
// - command 0x19 carries two bytes, the first a fan mask of value 0 to 15.
// - mask bit 0x01 is fan one, 0x02 fan two, 0x04 fan three, 0x08 fan four.
// - the second byte of 0x19 is a timeout in eighth-second ticks, 1 to 255.
// - a fail-safe fan not updated before its timeout is driven at full power.
// - each accepted command is answered with type code ORed with 0x40.
// - fan power is a pwm of the supply repeating at about 18 Hz.
// - tach edges are ignored for the configured counts of 552.5 us after turn-on.
// - tach edges while the pwm holds a fan off are ignored.
// - each blanking delay defaults to one count.
// - command 0x1A carries four delay bytes for fans one to four in order.
// - the delay settings are presented for saving as boot state.
// - query 0x1B returns the four power bytes and then the fail-safe mask.
// - fan four settings have no effect on any fan output.
`timescale 1ns/1ns
`include "ffs_consts.svh"
module ffs_fan_failsafe
  import ffs_pkg::*;
#(
  parameter int TICK_CYC = `FFS_TICK_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  // command byte stream: type, length, payload
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  // response byte stream: type, length, payload
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  // separate power update per fan
  input wire logic powerWrite,
  input wire logic [1:0] powerFan,
  input wire logic [7:0] powerValue,
  // fan supplies and tach lines
  output logic [`FFS_NFAN-1:0] fanOn,
  input wire logic [`FFS_NFAN-1:0] tachPin,
  output logic [`FFS_NFAN-1:0] tachEdge,
  // glitch delays for boot-state save
  output logic [31:0] glitchSave,
  // interrupt register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  ffs_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] len_reg;
  logic [7:0] idx_reg;
  logic [7:0] buf_reg [0:3];
  logic [2:0] txIdx_reg;
  logic [7:0] txLen_reg;
  logic [3:0] safeMask_reg;
  logic [7:0] timeout_reg;
  logic [7:0] glitch_reg [0:3];
  logic [7:0] power_reg [0:3];
  logic [7:0] ticksLeft_reg [0:3];
  logic [3:0] expired_reg;
  logic [31:0] tickCnt_reg;
  logic tickEn;
  logic [15:0] cntDiv_reg;
  logic cntEn;
  logic [7:0] phase_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic [3:0] evt;
  logic cmdDone;
  logic [3:0] tach1_reg;
  logic [3:0] tach2_reg;
  logic [3:0] tach3_reg;

  // ----------------------------------------
  // command parser
  // ----------------------------------------
  // payload is buffered and acted on only when complete and well formed
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= FFS_IDLE;
      cmd_reg <= 8'h00;
      len_reg <= 8'h00;
      idx_reg <= 8'h00;
      txIdx_reg <= 3'd0;
      txLen_reg <= 8'h00;
    end else begin
      case (state_reg)
        FFS_IDLE: begin
          if (rxValid) begin
            cmd_reg <= rxByte;
            state_reg <= FFS_LEN;
          end
        end
        FFS_LEN: begin
          if (rxValid) begin
            len_reg <= rxByte;
            idx_reg <= 8'h00;
            if ((cmd_reg == `FFS_CMD_FAILSAFE && rxByte == `FFS_LEN_FAILSAFE) ||
                (cmd_reg == `FFS_CMD_GLITCH && rxByte == `FFS_LEN_GLITCH)) begin
              state_reg <= FFS_DATA;
            end else if (cmd_reg == `FFS_CMD_QUERY && rxByte == `FFS_LEN_QUERY) begin
              txIdx_reg <= 3'd0;
              txLen_reg <= `FFS_LEN_QRSP;
              state_reg <= FFS_RESP;
            end else begin
              state_reg <= FFS_IDLE; // unknown or malformed: dropped
            end
          end
        end
        FFS_DATA: begin
          if (rxValid) begin
            idx_reg <= idx_reg + 8'h01;
            if (idx_reg + 8'h01 == len_reg) begin
              txIdx_reg <= 3'd0;
              txLen_reg <= 8'h00;
              state_reg <= FFS_RESP;
            end
          end
        end
        FFS_RESP: begin
          // type, length, then payload bytes
          if (txReady) begin
            txIdx_reg <= txIdx_reg + 3'd1;
            if ({5'd0, txIdx_reg} == txLen_reg + 8'h01) begin
              state_reg <= FFS_IDLE;
            end
          end
        end
        default: state_reg <= FFS_IDLE;
      endcase
    end
  end

  // payload capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) buf_reg[i] <= 8'h00;
    end else if (state_reg == FFS_DATA && rxValid) begin
      buf_reg[idx_reg[1:0]] <= rxByte;
    end
  end

  // last payload byte completes the command
  assign cmdDone = (state_reg == FFS_DATA) && rxValid && (idx_reg + 8'h01 == len_reg);

  // ----------------------------------------
  // response
  // ----------------------------------------
  always_comb begin
    txValid = (state_reg == FFS_RESP);
    txByte = 8'h00;
    if (state_reg == FFS_RESP) begin
      case (txIdx_reg)
        3'd0: txByte = cmd_reg | `FFS_RSP_FLAG;
        3'd1: txByte = txLen_reg;
        3'd2: txByte = power_reg[0];
        3'd3: txByte = power_reg[1];
        3'd4: txByte = power_reg[2];
        3'd5: txByte = power_reg[3];
        3'd6: txByte = {4'h0, safeMask_reg};
        default: txByte = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  // a mask above 15 is refused, leaving the old setting
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      safeMask_reg <= 4'h0;
      timeout_reg <= `FFS_TIMEOUT_RST;
    end else if (cmdDone && cmd_reg == `FFS_CMD_FAILSAFE && buf_reg[0] <= `FFS_MASK_MAX) begin
      safeMask_reg <= buf_reg[0][3:0];
      timeout_reg <= rxByte;
    end
  end

  // glitch delays, one count by default
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) glitch_reg[i] <= `FFS_GLITCH_RST;
    end else if (cmdDone && cmd_reg == `FFS_CMD_GLITCH) begin
      glitch_reg[0] <= buf_reg[0];
      glitch_reg[1] <= buf_reg[1];
      glitch_reg[2] <= buf_reg[2];
      glitch_reg[3] <= rxByte;
    end
  end
  assign glitchSave = {glitch_reg[3], glitch_reg[2], glitch_reg[1], glitch_reg[0]};

  // ----------------------------------------
  // timebases
  // ----------------------------------------
  // eighth-second tick and 552.5 us count enables
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_reg <= 32'd0;
      cntDiv_reg <= 16'd0;
      phase_reg <= 8'h00;
    end else begin
      tickCnt_reg <= tickEn ? 32'd0 : tickCnt_reg + 32'd1;
      cntDiv_reg <= cntEn ? 16'd0 : cntDiv_reg + 16'd1;
      if (cntEn) begin
        phase_reg <= (phase_reg == `FFS_PWM_STEPS - 8'd1) ? 8'h00 : phase_reg + 8'h01;
      end
    end
  end
  assign tickEn = (tickCnt_reg == 32'(TICK_CYC - 1));
  assign cntEn = (cntDiv_reg == 16'(`FFS_CNT_CYC - 1));

  // ----------------------------------------
  // per-fan power, watchdog, pwm and tach
  // ----------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tach1_reg <= 4'h0;
      tach2_reg <= 4'h0;
      tach3_reg <= 4'h0;
    end else begin
      tach1_reg <= tachPin;
      tach2_reg <= tach1_reg;
      tach3_reg <= tach2_reg;
    end
  end

  genvar f;
  generate
    for (f = 0; f < `FFS_NFAN; f++) begin : g_fan
      logic [7:0] blank_reg;
      logic on;
      logic upd;
      assign upd = powerWrite && (powerFan == 2'(f));
      // countdown restarts on each power update
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          power_reg[f] <= `FFS_POWER_RST;
          ticksLeft_reg[f] <= `FFS_TIMEOUT_RST;
          expired_reg[f] <= 1'b0;
        end else if (upd) begin
          power_reg[f] <= powerValue;
          ticksLeft_reg[f] <= timeout_reg;
          expired_reg[f] <= 1'b0;
        end else if (safeMask_reg[f] && tickEn && !expired_reg[f]) begin
          if (ticksLeft_reg[f] <= 8'h01) expired_reg[f] <= 1'b1;
          else ticksLeft_reg[f] <= ticksLeft_reg[f] - 8'h01;
        end
      end
      // expired fail-safe fans run full; fan four never drives its supply
      assign on = (f < `FFS_NLIVE) &&
                  ((safeMask_reg[f] && expired_reg[f]) ||
                   (phase_reg < power_reg[f]));
      // blanking counter reloads while off, counts down after turn-on
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          fanOn[f] <= 1'b0;
          blank_reg <= `FFS_GLITCH_RST;
          tachEdge[f] <= 1'b0;
        end else begin
          fanOn[f] <= on;
          if (!fanOn[f]) blank_reg <= glitch_reg[f];
          else if (cntEn && blank_reg != 8'h00) blank_reg <= blank_reg - 8'h01;
          tachEdge[f] <= fanOn[f] && on && (blank_reg == 8'h00) &&
                         (tach2_reg[f] != tach3_reg[f]) && (f < `FFS_NLIVE);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // interrupt status: 0 failsafe, 1 glitch, 2 query, 3 timeout
  // ----------------------------------------
  assign evt = {|(expired_reg & safeMask_reg),
                (state_reg == FFS_LEN) && rxValid && cmd_reg == `FFS_CMD_QUERY &&
                  rxByte == `FFS_LEN_QUERY,
                cmdDone && cmd_reg == `FFS_CMD_GLITCH,
                cmdDone && cmd_reg == `FFS_CMD_FAILSAFE};
  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= 4'h0;
      mask_reg <= 4'h0;
    end else begin
      if (regWrite && regAddr == `FFS_ADDR_STATUS) begin
        status_reg <= (status_reg & ~regWdata[3:0]) | evt;
      end else status_reg <= status_reg | evt;
      if (regWrite && regAddr == `FFS_ADDR_MASK) mask_reg <= regWdata[3:0];
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) regRdata <= 8'h00;
    else if (regRead) begin
      case (regAddr)
        `FFS_ADDR_STATUS: regRdata <= {4'h0, status_reg};
        `FFS_ADDR_MASK: regRdata <= {4'h0, mask_reg};
        `FFS_ADDR_SAFE: regRdata <= {4'h0, safeMask_reg};
        default: regRdata <= timeout_reg;
      endcase
    end else regRdata <= 8'h00;
  end
  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_failsafeCmd;
    cmdDone && cmd_reg == `FFS_CMD_FAILSAFE && buf_reg[0] <= `FFS_MASK_MAX;
  endsequence
  property p_failsafeLoad;
    @(posedge clock) disable iff (sys_rst)
    s_failsafeCmd |=> (safeMask_reg == $past(buf_reg[0][3:0])) && (timeout_reg == $past(rxByte));
  endproperty
  a_failsafeLoad: assert property (p_failsafeLoad) else $error("fail-safe config not loaded");
  property p_badMask;
    @(posedge clock) disable iff (sys_rst)
    (cmdDone && cmd_reg == `FFS_CMD_FAILSAFE && buf_reg[0] > `FFS_MASK_MAX) |=> $stable(safeMask_reg);
  endproperty
  a_badMask: assert property (p_badMask) else $error("bad mask accepted");
  property p_fullPower;
    @(posedge clock) disable iff (sys_rst)
    (safeMask_reg[2] && expired_reg[2] && !powerWrite) |=> fanOn[2];
  endproperty
  a_fullPower: assert property (p_fullPower) else $error("expired fan not at full power");
  property p_restart;
    @(posedge clock) disable iff (sys_rst)
    (powerWrite && powerFan == 2'd1) |=> (ticksLeft_reg[1] == $past(timeout_reg)) && !expired_reg[1];
  endproperty
  a_restart: assert property (p_restart) else $error("countdown not restarted");
  property p_respType;
    @(posedge clock) disable iff (sys_rst)
    (state_reg == FFS_RESP && txIdx_reg == 3'd0) |->
      (txByte == (`FFS_CMD_FAILSAFE | `FFS_RSP_FLAG)) ||
      (txByte == (`FFS_CMD_GLITCH | `FFS_RSP_FLAG)) ||
      (txByte == (`FFS_CMD_QUERY | `FFS_RSP_FLAG));
  endproperty
  a_respType: assert property (p_respType) else $error("bad response type");
  property p_offBlank;
    @(posedge clock) disable iff (sys_rst)
    !fanOn[1] |=> !tachEdge[1];
  endproperty
  a_offBlank: assert property (p_offBlank) else $error("tach edge while off");
  logic [7:0] blank_chk;
  assign blank_chk = g_fan[1].blank_reg;
  property p_blankWait;
    @(posedge clock) disable iff (sys_rst)
    (fanOn[1] && blank_chk != 8'h00) |=> !tachEdge[1];
  endproperty
  a_blankWait: assert property (p_blankWait) else $error("tach edge during blanking");
  property p_fanFour;
    @(posedge clock) disable iff (sys_rst)
    !fanOn[3] && !tachEdge[3];
  endproperty
  a_fanFour: assert property (p_fanFour) else $error("fan four active");
  property p_queryLen;
    @(posedge clock) disable iff (sys_rst)
    (state_reg == FFS_RESP && cmd_reg == `FFS_CMD_QUERY && txIdx_reg == 3'd1) |->
      txByte == `FFS_LEN_QRSP;
  endproperty
  a_queryLen: assert property (p_queryLen) else $error("query length wrong");
endmodule : ffs_fan_failsafe

// [verif/ffs_host_model.sv]
// host side model: sends command packets and collects response bytes
`timescale 1ns/1ns
module ffs_host_model (
  input wire logic clock,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic txReady,
  input wire logic txValid,
  input wire logic [7:0] txByte
);
  logic [7:0] rsp[$];
  logic slow;

  // idle values; the byte line never keeps showing stale data
  initial begin
    rxValid = 1'b0;
    rxByte = 8'hA5;
    txReady = 1'b1;
    slow = 1'b0;
  end

  // one packet: type, length, then payload bytes from the top of pay
  task automatic send_pkt(input logic [7:0] typ, input logic [7:0] len, input logic [31:0] pay);
    logic [7:0] b;
    for (int i = 0; i < int'(len) + 2; i++) begin
      b = (i == 0) ? typ : (i == 1) ? len : pay[31-8*(i-2) -: 8];
      @(posedge clock);
      rxValid <= 1'b1;
      rxByte <= b;
    end
    @(posedge clock);
    rxValid <= 1'b0;
    rxByte <= ~b;
  endtask : send_pkt

  // sink: when slow, ready toggles each cycle so response bytes are taken at most every other cycle
  always @(posedge clock) begin
    if (txValid && txReady) begin
      rsp.push_back(txByte);
    end
    txReady <= slow ? ~txReady : 1'b1;
  end
endmodule : ffs_host_model

// [verif/fan_failsafe_tach_control_tb.sv]
// self-checking bench for the fan fail-safe and tach blanking block
`timescale 1ns/1ns
`include "ffs_consts.svh"
module fan_failsafe_tach_control_tb
  import ffs_pkg::*;
;
  localparam int TICK = 50;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic rxValid, txReady, txValid, powerWrite, regWrite, regRead, irq;
  logic [7:0] rxByte, txByte, powerValue, regWdata, regRdata, d;
  logic [1:0] powerFan, regAddr;
  logic [3:0] fanOn, tachPin, tachEdge;
  logic [31:0] glitchSave;
  int fails = 0;
  int checks_done = 0;
  int tachCnt = 0;

  always #20 clock = ~clock;

  ffs_host_model host (.clock(clock), .rxValid(rxValid), .rxByte(rxByte), .txReady(txReady),
    .txValid(txValid), .txByte(txByte));

  ffs_fan_failsafe #(.TICK_CYC(TICK)) dut (.clock(clock), .sys_rst(sys_rst), .rxValid(rxValid),
    .rxByte(rxByte), .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .powerWrite(powerWrite), .powerFan(powerFan), .powerValue(powerValue), .fanOn(fanOn),
    .tachPin(tachPin), .tachEdge(tachEdge), .glitchSave(glitchSave), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq));

  // accepted tach edges of fan two
  always @(posedge clock) begin
    if (tachEdge[1] === 1'b1) tachCnt++;
  end

  //----------------------------------------
  // shared tasks
  //----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : reg_wr

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask : reg_rd

  task automatic pwr_wr(input logic [1:0] f, input logic [7:0] v);
    @(posedge clock);
    powerWrite <= 1'b1;
    powerFan <= f;
    powerValue <= v;
    @(posedge clock);
    powerWrite <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pwr_wr

  // send a packet, wait for n response bytes, compare them from the top of exp
  task automatic cmd(input logic [7:0] typ, input logic [7:0] len, input logic [31:0] pay,
    input int n, input logic [55:0] exp);
    int w;
    host.rsp.delete();
    host.send_pkt(typ, len, pay);
    w = 0;
    while (host.rsp.size() < n && w < 500) begin
      @(posedge clock);
      w++;
    end
    repeat (4) @(posedge clock);
    chk(host.rsp.size(), n);
    for (int i = 0; i < n && i < host.rsp.size(); i++) chk(host.rsp[i], exp[55-8*i -: 8]);
  endtask : cmd

  task automatic tach_flip();
    @(posedge clock);
    tachPin[1] <= ~tachPin[1];
  endtask : tach_flip

  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_reset();
    // outputs settle over the first edges after release
    repeat (2) @(negedge clock);
    chk(glitchSave, 32'h01010101);
    chk(fanOn, 4'h7);
    chk(tachEdge, 4'h0);
    chk(txValid, 1'b0);
    chk(irq, 1'b0);
    reg_rd(2'h0, d);
    chk(d, 8'h00);
  endtask : t_reset

  task automatic t_query();
    host.slow = 1'b1;
    cmd(8'h1B, 8'h00, 32'h0, 7, 56'h5B056464646400);
    host.slow = 1'b0;
  endtask : t_query

  task automatic t_blank();
    pwr_wr(2'h1, 8'h00);
    tach_flip();
    repeat (10) @(posedge clock);
    chk(tachCnt, 0);
    pwr_wr(2'h1, 8'h64);
    tach_flip();
    repeat (20) @(posedge clock);
    chk(tachCnt, 0);
    repeat (14000) @(posedge clock);
    tach_flip();
    repeat (10) @(posedge clock);
    chk(tachCnt, 1);
  endtask : t_blank

  task automatic t_glitch();
    cmd(8'h1A, 8'h04, 32'h05060708, 2, 56'h5A000000000000);
    chk(glitchSave, 32'h08070605);
  endtask : t_glitch

  // reset in mid-run brings back default delays and full power
  task automatic t_rerst();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clock);
    chk(glitchSave, 32'h01010101);
    chk(fanOn, 4'h7);
    chk(txValid, 1'b0);
  endtask : t_rerst

  task automatic t_failsafe();
    pwr_wr(2'h0, 8'h00);
    pwr_wr(2'h2, 8'h00);
    chk(fanOn[2], 1'b0);
    cmd(8'h19, 8'h02, 32'h04020000, 2, 56'h59000000000000);
    reg_rd(2'h2, d);
    chk(d, 8'h04);
    reg_rd(2'h3, d);
    chk(d, 8'h02);
    // query now shows the lowered powers and the fail-safe mask
    cmd(8'h1B, 8'h00, 32'h0, 7, 56'h5B050064006404);
    // updates closer than one tick keep the fan off
    for (int i = 0; i < 5; i++) begin
      pwr_wr(2'h2, 8'h00);
      repeat (40) @(posedge clock);
      chk(fanOn[2], 1'b0);
    end
    repeat (2 * TICK + 20) @(posedge clock);
    chk(fanOn[2], 1'b1);
    chk(fanOn[0], 1'b0);
    chk(irq, 1'b0);
    reg_wr(2'h1, 8'h08);
    repeat (2) @(posedge clock);
    chk(irq, 1'b1);
    pwr_wr(2'h2, 8'h00);
    reg_wr(2'h0, 8'h0F);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    // out-of-range mask answered but not applied; read-only place ignores writes
    cmd(8'h19, 8'h02, 32'h1F050000, 2, 56'h59000000000000);
    reg_wr(2'h2, 8'h00);
    reg_rd(2'h2, d);
    chk(d, 8'h04);
    cmd(8'h19, 8'h02, 32'h00020000, 2, 56'h59000000000000);
  endtask : t_failsafe

  //----------------------------------------
  // main sequence and watchdog
  //----------------------------------------
  initial begin
    powerWrite = 1'b0;
    powerFan = 2'h0;
    powerValue = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 2'h0;
    regWdata = 8'h00;
    tachPin = 4'h0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_query();
    t_blank();
    t_glitch();
    t_rerst();
    t_failsafe();
    final_report();
  end

  // the run needs about 15k cycles; a hang is cut well beyond that
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule : fan_failsafe_tach_control_tb
